// ### testbench.sv
// self-checking bench for the trace line formatter
`default_nettype none
`include "tlf_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals, clock, design and core model
  // ----------------------------------------
  logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, cof_v, sd, va, bus_v, sz, dir, op_v;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [17:0] cof_a, bus_a, op_pc;
  logic [15:0] bus_d;
  int          n_mismatch = 0;
  int          checked = 0;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  tlf_core_model core (.clk(clk), .cof_valid(cof_v), .cof_addr(cof_a), .source_dest_flag(sd),
    .vector_flag(va), .bus_valid(bus_v), .bus_addr(bus_a), .bus_data(bus_d),
    .access_size_flag(sz), .access_direction_flag(dir), .op_valid(op_v), .op_pc(op_pc));
  tlf_trace_line_formatter uut (.clk(clk), .rst_b(rst_b), .cof_valid(cof_v), .cof_addr(cof_a),
    .source_dest_flag(sd), .vector_flag(va), .bus_valid(bus_v), .bus_addr(bus_a),
    .bus_data(bus_d), .access_size_flag(sz), .access_direction_flag(dir), .op_valid(op_v),
    .op_pc(op_pc), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ----------------------------------------
  // compare, verdict and bus tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_up;
    n_mismatch++;
    $display("mismatch bus answer expected within 64 cycles seen none");
    report_and_stop();
  endtask
  task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    hb = 1'b0;
    @(posedge clk); // keep the last release and this request apart
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    for (int n = 0; n < 64 && !hb; n++) begin
      @(negedge clk);
      {ha, hw, hb} = {awvalid & awready, wvalid & wready, bvalid & bready};
      if (hb) chk("bresp", {30'h0, er}, {30'h0, bresp});
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end
    if (!hb) give_up();
  endtask
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp,
                        input logic [1:0] er);
    logic ha, hr;
    hr = 1'b0;
    @(posedge clk); // keep the last release and this request apart
    {araddr, arvalid, rready} <= {a, 2'h3};
    for (int n = 0; n < 64 && !hr; n++) begin
      @(negedge clk);
      {ha, hr} = {arvalid & arready, rvalid & rready};
      if (hr) chk(what, exp, rdata);
      if (hr) chk("rresp", {30'h0, er}, {30'h0, rresp});
      @(posedge clk);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
    end
    if (!hr) give_up();
  endtask
  task automatic line(input logic [19:0] exp);
    rd_chk("line low", `TLF_RDATA_OFF, {16'h0, exp[15:0]}, `TLF_RESP_OKAY);
    rd_chk("line high", `TLF_RDATA_OFF, {28'h0, exp[19:16]}, `TLF_RESP_OKAY);
  endtask
  task automatic start(input logic [1:0] mode);
    rst_b <= 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    wr_chk(`TLF_CTRL_OFF, {29'h0, mode, 1'b1}, `TLF_RESP_OKAY);
  endtask
  task automatic stop(input logic [6:0] n);
    wr_chk(`TLF_CTRL_OFF, 32'h0, `TLF_RESP_OKAY);
    rd_chk("line count", `TLF_STAT_OFF, {25'h0, n}, `TLF_RESP_OKAY);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    start(`TLF_MODE_NORMAL);
    stop(7'h00);
    rd_chk("ctrl", `TLF_CTRL_OFF, `TLF_CTRL_RST_VAL, `TLF_RESP_OKAY);
    rd_chk("unmapped", 12'h010, 32'h0, `TLF_RESP_SLVERR);
    wr_chk(12'h010, 32'hffff_ffff, `TLF_RESP_SLVERR);
    $display("test regs done");
  endtask
  task automatic t_normal;
    start(`TLF_MODE_NORMAL);
    core.cof(18'h2_a5c3, 1'b0, 1'b0);
    core.cof(18'h1_0040, 1'b1, 1'b1);
    core.cof(18'h3_ffff, 1'b1, 1'b0);
    rd_chk("locked read", `TLF_RDATA_OFF, 32'h0, `TLF_RESP_OKAY);
    stop(7'h03);
    line(20'h2_a5c3);
    line(20'hd_0040);
    line(20'hb_ffff);
    $display("test normal done");
  endtask
  task automatic t_loop;
    start(`TLF_MODE_LOOP);
    repeat (2) core.cof(18'h0_0123, 1'b0, 1'b0);
    repeat (2) core.cof(18'h0_0123, 1'b1, 1'b0);
    stop(7'h03);
    line(20'h0_0123);
    line(20'h8_0123);
    line(20'h8_0123);
    $display("test loop done");
  endtask
  task automatic t_detail;
    start(`TLF_MODE_DETAIL);
    core.bus(18'h3_1234, 16'h77ab, 1'b1, 1'b1);
    core.bus(18'h0_5678, 16'hc3d2, 1'b0, 1'b0);
    stop(7'h04);
    line(20'hf_1234);
    line(20'h0_00ab);
    line(20'h0_5678);
    line(20'h0_c3d2);
    $display("test detail done");
  endtask
  task automatic t_packed;
    logic [17:0] pcs [8] = '{18'h0_1000, 18'h0_1005, 18'h0_1012, 18'h0_103f, 18'h0_1001,
                             18'h2_0040, 18'h2_0041, 18'h2_0043};
    start(`TLF_MODE_PACKED);
    foreach (pcs[i]) core.op(pcs[i]);
    stop(7'h05);
    line({2'b00, 18'h0_1000});
    line({2'b11, 6'h3f, 6'h12, 6'h05});
    line({2'b01, 12'h000, 6'h01});
    line({2'b00, 18'h2_0040});
    line({2'b10, 6'h00, 6'h03, 6'h01});
    $display("test packed done");
  endtask
  task automatic t_wrap;
    start(`TLF_MODE_PACKED);
    for (int i = 0; i < 64; i++) core.op(18'(i * 64));
    core.op(18'h0_0fc5);
    core.op(18'h0_0fc6);
    wr_chk(`TLF_CTRL_OFF, 32'h0, `TLF_RESP_OKAY);
    rd_chk("line count", `TLF_STAT_OFF, 32'h0000_0142, `TLF_RESP_OKAY);
    wr_chk(`TLF_RPTR_OFF, 32'h0, `TLF_RESP_OKAY);
    rd_chk("read pointer", `TLF_RPTR_OFF, 32'h2, `TLF_RESP_OKAY);
    for (int k = 2; k < 64; k++) line({2'b00, 18'(k * 64)});
    line({2'b00, 18'h0_0fc5});
    line({2'b01, 12'h000, 6'h06});
    $display("test wrap done");
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 56'h0;
    t_regs();
    t_normal();
    t_loop();
    t_detail();
    t_packed();
    t_wrap();
    report_and_stop();
  end
endmodule
bind tlf_trace_line_formatter tlf_checker chk_i (.clk(clk), .rst_b(rst_b),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// ### tlf_checker.sv
// handshake and readout checks for the trace line formatter
`default_nettype none
`include "tlf_regs.vh"
module tlf_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // read address held for the answer
  // ----------------------------------------
  logic [11:0] rd_addr_ff;
  logic        map_ok;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rd_addr_ff <= 12'h000;
    else if (s_axi_arvalid && s_axi_arready) rd_addr_ff <= s_axi_araddr;
  end
  assign map_ok = (rd_addr_ff[11:4] == 8'h00);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
    $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer dropped");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  a_line_width: assert property (
    s_axi_rvalid && rd_addr_ff == `TLF_RDATA_OFF |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("buffer word too wide");
  a_unmapped_err: assert property (s_axi_rvalid && !map_ok |->
    s_axi_rresp == `TLF_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_mapped_okay: assert property (s_axi_rvalid && map_ok |-> s_axi_rresp == `TLF_RESP_OKAY)
    else $error("mapped read refused");
endmodule
`default_nettype wire

// ### tlf_core_model.sv
// traced core model driving trace pulses into the formatter
`default_nettype none
module tlf_core_model (
  input  wire logic        clk,
  output var  logic        cof_valid,
  output var  logic [17:0] cof_addr,
  output var  logic        source_dest_flag,
  output var  logic        vector_flag,
  output var  logic        bus_valid,
  output var  logic [17:0] bus_addr,
  output var  logic [15:0] bus_data,
  output var  logic        access_size_flag,
  output var  logic        access_direction_flag,
  output var  logic        op_valid,
  output var  logic [17:0] op_pc
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // one pulse per call, payload inverted once stale, idle cycle after
  // ----------------------------------------
  initial begin
    {cof_valid, cof_addr, source_dest_flag, vector_flag} = 21'h00000;
    {bus_valid, bus_addr, bus_data, access_size_flag, access_direction_flag} = 37'h0;
    {op_valid, op_pc} = 19'h00000;
  end
  task automatic cof(input logic [17:0] a, input logic sd, input logic va);
    {cof_addr, source_dest_flag, vector_flag, cof_valid} <= {a, sd, va, 1'b1};
    @(posedge clk);
    {cof_addr, source_dest_flag, vector_flag, cof_valid} <= {~a, ~sd, ~va, 1'b0};
    @(posedge clk);
  endtask
  task automatic bus(input logic [17:0] a, input logic [15:0] d, input logic sz,
                     input logic rd);
    {bus_addr, bus_data, access_size_flag, access_direction_flag} <= {a, d, sz, rd};
    bus_valid <= 1'b1;
    @(posedge clk);
    {bus_addr, bus_data, access_size_flag, access_direction_flag} <= ~{a, d, sz, rd};
    bus_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic op(input logic [17:0] pc);
    {op_pc, op_valid} <= {pc, 1'b1};
    @(posedge clk);
    {op_pc, op_valid} <= {~pc, 1'b0};
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### tlf_regs.vh
// register map, field positions and constants for the trace line formatter
`ifndef TLF_REGS_VH
`define TLF_REGS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TLF_CTRL_OFF      12'h000
`define TLF_STAT_OFF      12'h004
`define TLF_RDATA_OFF     12'h008
`define TLF_RPTR_OFF      12'h00c
// ----------------------------------------
// control fields
// ----------------------------------------
`define TLF_CTRL_EN_BIT   0
`define TLF_CTRL_MODE_LSB 1
`define TLF_CTRL_MODE_MSB 2
`define TLF_CTRL_RST_VAL  32'h0000_0000
// trace modes
`define TLF_MODE_NORMAL   2'h0
`define TLF_MODE_LOOP     2'h1
`define TLF_MODE_DETAIL   2'h2
`define TLF_MODE_PACKED   2'h3
// ----------------------------------------
// buffer geometry
// ----------------------------------------
`define TLF_DEPTH         64
`define TLF_LINE_W        20
`define TLF_IDX_W         6
`define TLF_CNT_W         7
// packed line kinds
`define TLF_KIND_BASE     2'h0
`define TLF_KIND_ONE      2'h1
`define TLF_KIND_TWO      2'h2
`define TLF_KIND_THREE    2'h3
// axi responses
`define TLF_RESP_OKAY     2'h0
`define TLF_RESP_SLVERR   2'h2
`endif

// ### tlf_trace_line_formatter.v
// trace line formatter: formats trace records into a 64x20 circular buffer
//
// Summary of operation
// - detail mode stores address line then data line, so 32 entries fit.
// - detail mode counter advances twice per entry, once per line.
// - normal and loop modes share layout: flags with pc bits 17:16, then pc bytes.
// - detail address line upper field holds size, direction, address 17:16; data line zero.
// - byte access data goes to low byte, high byte zero.
// - word access puts lower-address byte in byte1, higher in byte0.
// - detail upper bit 3 is size: 0 word, 1 byte.
// - detail upper bit 2 is direction: 0 write, 1 read.
// - detail upper bits 1:0 carry address bits 17 and 16.
// - flow upper bit 3 marks source 0 or destination 1.
// - flow upper bit 2 marks vector; a vector also sets destination bit.
// - flow upper bits 1:0 hold pc bits 17 and 16.
// - packed kind 00 carries a full 18-bit base pc.
// - packed kind 01 holds one 6-bit offset in bits 5:0.
// - packed kind 10 holds two offsets in bits 11:0.
// - packed kind 11 holds three offsets in bits 17:0.
// - new base line whenever pc bits 17:6 differ from previous base.
// - offsets are the low six pc bits, relative to 64-address block start.
// - first buffer line in packed mode is always a base line, also on wrap.
// - store is 64 lines of 20 bits, circular; counter rises on every new line, not on packed merges.
// - readout gives low 16 bits first, then upper 4 bits with zeros above.
//
// ----------------------------------------
// usage notes
// ----------------------------------------
// buffer lines survive reset; pointers, counter and control do not
// counter is seven bits wide and rolls over after 128 new lines
// detail mode ignores a bus access while its data line is written
// loop filter drops repeated source addresses only, never destinations
// clearing the enable restarts packing: next op opens a base line
// in packed mode a new line landing on index zero is always a base line
// data word reads as zero while tracing is on, pointer kept
// a pointer register write restarts readout at the oldest line unless a data word read with tracing off lands in the same cycle
// unmapped addresses answer slave error and read as zero
// misaligned byte offsets decode to their aligned word
// control update needs write strobe bit zero
// one write and one read may be in flight at a time
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`default_nettype none
`include "tlf_regs.vh"

module tlf_trace_line_formatter (
  input  wire        clk,
  input  wire        rst_b,
  // core trace inputs
  input  wire        cof_valid,
  input  wire [17:0] cof_addr,
  input  wire        source_dest_flag,
  input  wire        vector_flag,
  input  wire        bus_valid,
  input  wire [17:0] bus_addr,
  input  wire [15:0] bus_data,
  input  wire        access_size_flag,
  input  wire        access_direction_flag,
  input  wire        op_valid,
  input  wire [17:0] op_pc,
  // axi4-lite slave
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  // circular store, write pointer and line counter
  reg [`TLF_LINE_W-1:0] mem_ff [0:`TLF_DEPTH-1];
  reg [`TLF_IDX_W-1:0]  wptr_ff;
  reg [`TLF_CNT_W-1:0]  valid_line_counter_ff;
  reg                   wrapped_ff;
  // control register fields
  reg                   en_ff;
  reg [1:0]             mode_ff;
  // loop filter: last stored address
  reg [17:0]            loop_last_ff;
  reg                   loop_have_ff;
  // detail mode pending data line
  reg                   data_pend_ff;
  reg [15:0]            data_line_ff;
  // packed mode state
  reg                   base_have_ff;
  reg [11:0]            base_hi_ff;
  reg [1:0]             slots_ff;
  reg [17:0]            pack_ff;
  reg [`TLF_IDX_W-1:0]  pack_idx_ff;
  // readout state
  reg [`TLF_IDX_W-1:0]  rptr_ff;
  reg                   rhalf_ff;
  // bus latches
  reg                   aw_have_ff;
  reg [11:0]            aw_addr_ff;
  reg                   w_have_ff;
  reg [31:0]            w_data_ff;
  reg [3:0]             w_strb_ff;

  // ----------------------------------------
  // line formatting functions
  // ----------------------------------------
  // flow line: flags, prog_counter_top_bit:16, mid and low bytes
  function [19:0] flow_line;
    input [17:0] a;
    input        sd;
    input        va;
    begin
      flow_line = {sd | va, va, a[17:16], a[15:0]};
    end
  endfunction

  // detail data line: byte goes low with high cleared, word keeps lower address in byte1
  function [15:0] data_fmt;
    input [15:0] d;
    input        byte_acc;
    begin
      if (byte_acc) begin
        data_fmt = {8'h00, d[7:0]};
      end else begin
        data_fmt = d;
      end
    end
  endfunction

  // next index round the circular store
  function [`TLF_IDX_W-1:0] ptr_inc;
    input [`TLF_IDX_W-1:0] p;
    begin
      ptr_inc = p + 6'h01;
    end
  endfunction

  // valid-line counter step, rolls over at its width
  function [`TLF_CNT_W-1:0] cnt_inc;
    input [`TLF_CNT_W-1:0] c;
    begin
      cnt_inc = c + 7'h01;
    end
  endfunction

  // ----------------------------------------
  // write side decode
  // ----------------------------------------
  wire        mode_detail = (mode_ff == `TLF_MODE_DETAIL);
  wire        mode_packed = (mode_ff == `TLF_MODE_PACKED);
  wire        mode_loop   = (mode_ff == `TLF_MODE_LOOP);
  // loop filter: source address repeating the last stored address, source or destination
  wire        loop_dup    = mode_loop && loop_have_ff && !source_dest_flag && !vector_flag &&
                            (cof_addr == loop_last_ff);
  wire        cof_store   = en_ff && !mode_detail && !mode_packed && cof_valid && !loop_dup;
  // detail mode takes a bus access only when no data line waits
  wire        det_addr    = en_ff && mode_detail && bus_valid && !data_pend_ff;
  wire        det_data    = en_ff && mode_detail && data_pend_ff;
  // packed mode: one event per executed opcode
  wire        pk_op       = en_ff && mode_packed && op_valid;
  // next packed op needs a line of its own
  wire        pk_open     = (slots_ff == 2'h0) || (slots_ff == 2'h3);
  // new base on block change or when a fresh line would land on index zero
  wire        pk_newbase  = !base_have_ff || (op_pc[17:6] != base_hi_ff) ||
                            (pk_open && wptr_ff == {`TLF_IDX_W{1'b0}});
  wire [1:0]  pk_slots_n  = (slots_ff == 2'h3) ? 2'h1 : slots_ff + 2'h1;
  // a fresh line is taken at the write pointer this cycle
  wire        line_new    = cof_store || det_addr || det_data ||
                            (pk_op && (pk_newbase || pk_open));

  // ----------------------------------------
  // trace store process
  // ----------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // buffer lines keep their contents over reset
      wptr_ff               <= {`TLF_IDX_W{1'b0}};
      valid_line_counter_ff <= {`TLF_CNT_W{1'b0}};
      wrapped_ff            <= 1'b0;
      loop_last_ff          <= 18'h00000;
      loop_have_ff          <= 1'b0;
      data_pend_ff          <= 1'b0;
      data_line_ff          <= 16'h0000;
      base_have_ff          <= 1'b0;
      base_hi_ff            <= 12'h000;
      slots_ff              <= 2'h0;
      pack_ff               <= 18'h00000;
      pack_idx_ff           <= {`TLF_IDX_W{1'b0}};
    end else if (!en_ff) begin
      // tracing off: restart packing and loop filter for next session
      base_have_ff <= 1'b0;
      slots_ff     <= 2'h0;
      loop_have_ff <= 1'b0;
      data_pend_ff <= 1'b0;
    end else begin
      if (cof_store) begin
        mem_ff[wptr_ff] <= flow_line(cof_addr, source_dest_flag, vector_flag);
        loop_last_ff    <= cof_addr;
        loop_have_ff    <= 1'b1;
        wptr_ff         <= ptr_inc(wptr_ff);
        valid_line_counter_ff <= cnt_inc(valid_line_counter_ff);
      end
      if (det_addr) begin
        // address line now, data line next cycle
        mem_ff[wptr_ff] <= {access_size_flag, access_direction_flag, bus_addr[17:16],
                            bus_addr[15:0]};
        data_line_ff <= data_fmt(bus_data, access_size_flag);
        data_pend_ff <= 1'b1;
        wptr_ff      <= ptr_inc(wptr_ff);
        valid_line_counter_ff <= cnt_inc(valid_line_counter_ff);
      end
      if (det_data) begin
        mem_ff[wptr_ff] <= {4'h0, data_line_ff};
        data_pend_ff    <= 1'b0;
        wptr_ff         <= ptr_inc(wptr_ff);
        valid_line_counter_ff <= cnt_inc(valid_line_counter_ff);
      end
      if (pk_op) begin
        if (pk_newbase) begin
          // close any partial line, write full base
          mem_ff[wptr_ff] <= {`TLF_KIND_BASE, op_pc};
          base_hi_ff   <= op_pc[17:6];
          base_have_ff <= 1'b1;
          slots_ff     <= 2'h0;
          wptr_ff      <= ptr_inc(wptr_ff);
          valid_line_counter_ff <= cnt_inc(valid_line_counter_ff);
        end else if (pk_open) begin
          // open a new offset line in the lowest slot
          mem_ff[wptr_ff] <= {`TLF_KIND_ONE, 12'h000, op_pc[5:0]};
          pack_ff     <= {12'h000, op_pc[5:0]};
          pack_idx_ff <= wptr_ff;
          slots_ff    <= 2'h1;
          wptr_ff     <= ptr_inc(wptr_ff);
          valid_line_counter_ff <= cnt_inc(valid_line_counter_ff);
        end else if (slots_ff == 2'h1) begin
          mem_ff[pack_idx_ff] <= {`TLF_KIND_TWO, 6'h00, op_pc[5:0], pack_ff[5:0]};
          pack_ff  <= {6'h00, op_pc[5:0], pack_ff[5:0]};
          slots_ff <= pk_slots_n;
        end else begin
          mem_ff[pack_idx_ff] <= {`TLF_KIND_THREE, op_pc[5:0], pack_ff[11:0]};
          pack_ff  <= {op_pc[5:0], pack_ff[11:0]};
          slots_ff <= pk_slots_n;
        end
      end
      // last index written: the store has come round
      if (line_new && wptr_ff == 6'h3f) begin
        wrapped_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  // ready while nothing is held and no answer is pending
  assign s_axi_awready = !aw_have_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_ff && !s_axi_bvalid;
  wire   wr_go         = aw_have_ff && w_have_ff;
  wire   wr_ctrl       = wr_go && aw_addr_ff == `TLF_CTRL_OFF;
  wire   wr_rptr       = wr_go && aw_addr_ff == `TLF_RPTR_OFF;
  wire   wr_ok         = wr_ctrl || wr_rptr || (aw_addr_ff == `TLF_STAT_OFF) ||
                         (aw_addr_ff == `TLF_RDATA_OFF);
  // oldest line index: zero before wrap, write pointer after
  wire [`TLF_IDX_W-1:0] oldest = wrapped_ff ? wptr_ff : {`TLF_IDX_W{1'b0}};

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_have_ff   <= 1'b0;
      aw_addr_ff   <= 12'h000;
      w_have_ff    <= 1'b0;
      w_data_ff    <= 32'h0000_0000;
      w_strb_ff    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TLF_RESP_OKAY;
      en_ff        <= 1'b0;
      mode_ff      <= `TLF_MODE_NORMAL;
    end else begin
      // address and data may arrive in either order
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_ff <= 1'b1;
        aw_addr_ff <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      // both halves held: answer and apply
      if (wr_go) begin
        aw_have_ff   <= 1'b0;
        w_have_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `TLF_RESP_OKAY : `TLF_RESP_SLVERR;
        if (wr_ctrl && w_strb_ff[0]) begin
          en_ff   <= w_data_ff[`TLF_CTRL_EN_BIT];
          mode_ff <= w_data_ff[`TLF_CTRL_MODE_MSB:`TLF_CTRL_MODE_LSB];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // axi4-lite read channel and buffer readout
  // ----------------------------------------
  // read address decoded on word boundaries
  assign s_axi_arready = !s_axi_rvalid;
  wire [11:0] ar_a     = {s_axi_araddr[11:2], 2'h0};
  wire [`TLF_LINE_W-1:0] rline = mem_ff[rptr_ff];

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `TLF_RESP_OKAY;
      rptr_ff      <= {`TLF_IDX_W{1'b0}};
      rhalf_ff     <= 1'b0;
    end else begin
      if (wr_rptr) begin
        // restart readout at the oldest line
        rptr_ff  <= oldest;
        rhalf_ff <= 1'b0;
      end
      // one read answered at a time
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `TLF_RESP_OKAY;
        case (ar_a)
          `TLF_CTRL_OFF: begin
            s_axi_rdata <= {29'h0, mode_ff, en_ff};
          end
          `TLF_STAT_OFF: begin
            s_axi_rdata <= {23'h0, wrapped_ff, 1'b0, valid_line_counter_ff};
          end
          `TLF_RDATA_OFF: begin
            if (en_ff) begin
              s_axi_rdata <= 32'h0000_0000; // no readout while tracing
            end else if (!rhalf_ff) begin
              s_axi_rdata <= {16'h0000, rline[15:0]};
              rhalf_ff    <= 1'b1;
            end else begin
              s_axi_rdata <= {28'h0, rline[19:16]};
              rhalf_ff    <= 1'b0;
              rptr_ff     <= ptr_inc(rptr_ff);
            end
          end
          `TLF_RPTR_OFF: begin
            s_axi_rdata <= {25'h0, rhalf_ff, rptr_ff};
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TLF_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire
